// File: rtl/vir_top.sv
// vme interrupt vector capture (levels 5-7) and interrupt routing registers
// assumes avalon-mm master with waitrequest; ack port driven by vme side logic
// Functional notes
// [RULE1] each handled level has a read-only register, low byte is captured vector
// [RULE2] level 5, 6, 7 registers store only vectors acknowledged at their own level
// [RULE3] level is handled only while its enable bit is set
// [RULE4] no new acknowledge at a level until its status bit is cleared
// [RULE5] capture writes the vector field and raises the local interrupt
// [RULE6] bus error during capture sets the level error flag
// [RULE7] error flag 0 clean, 1 bus error; flag and vector reset to zero
// [RULE8] local route register: eight 3-bit rw fields, monitors and mailboxes, reset zero
// [RULE9] local route value n selects local interrupt line n
// [RULE10] vme route register at 0x344: four mailbox fields, upper 16 bits reserved
// [RULE11] vme route value n selects vme line n; zero masks the source
// [RULE12] mailbox write is an interrupt source delivered when enabled
// [RULE13] route fields sit in low three bits of each nibble; top bit reads zero
// [RULE14] vector error flag at bit 8; reserved bits read zero, ignore writes
`timescale 1ns/1ps
module vir_top #(
   parameter int NUM_LEVELS = vir_pkg::NUM_LEVELS
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [NUM_LEVELS-1:0] vme_irq_pending,
   output logic [NUM_LEVELS-1:0] vme_ack_req,
   input wire logic [NUM_LEVELS-1:0] vme_ack_done,
   input wire logic [7:0] vme_ack_vector,
   input wire logic vme_ack_berr,
   input wire logic [3:0] locmon_event,
   output logic [7:0] local_irq_line,
   output logic [6:0] vme_irq_line,
   output logic irq
);
   initial begin
      if (NUM_LEVELS != vir_pkg::NUM_LEVELS) begin
         $error("vir_top serves exactly three vme levels");
      end
   end

   typedef struct packed {
      logic [31:0] local_route;
      logic [31:0] vme_route;
      logic [31:0] enable;
      logic [31:0] status;
      logic [3:0][31:0] mailbox;
      logic [31:0] rdata;
      logic wait_n;
      logic [7:0] lline;
      logic [6:0] vline;
      logic irq;
   } vir_top_state_t;

   vir_top_state_t s_q;
   vir_top_state_t s_d;

   logic [NUM_LEVELS-1:0] cap_pulse;
   logic [NUM_LEVELS-1:0] ack_req;
   vir_pkg::vir_capture_t [NUM_LEVELS-1:0] cap;

   // one handler per level; vector/berr are shared, done is per level and only own done is seen
   for (genvar g = 0; g < NUM_LEVELS; g++) begin : g_lvl
      vir_level_handler u_lvl (
         .clock(clock),
         .rst_n(rst_n),
         .enable(s_q.enable[vir_pkg::STAT_LEVEL_LSB + g]), // [RULE3]
         .irq_pending(vme_irq_pending[g]),
         .status_set(s_q.status[vir_pkg::STAT_LEVEL_LSB + g]), // [RULE4]
         .ack_req(ack_req[g]),
         .ack_done(vme_ack_done[g] & ack_req[g]), // [RULE2]
         .ack_vector(vme_ack_vector),
         .ack_berr(vme_ack_berr),
         .capture(cap_pulse[g]),
         .captured(cap[g])
      );
   end

   // ack requests are handler requests registered once more, dropped while done is high
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         vme_ack_req <= '0;
      end else begin
         vme_ack_req <= ack_req & ~vme_ack_done;
      end
   end

   // byte-lane merge for writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be, input logic [31:0] keep);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r & keep;
   endfunction : merge

   logic [31:0] vec_word [NUM_LEVELS];
   always_comb begin
      for (int i = 0; i < NUM_LEVELS; i++) begin
         vec_word[i] = '0;
         vec_word[i][7:0] = cap[i].vector; // [RULE1]
         vec_word[i][vir_pkg::VEC_ERR_BIT] = cap[i].err; // [RULE14] [RULE7]
      end
   end

   logic acc;
   logic [3:0] mbox_wr;
   logic [31:0] set_bits;
   logic [31:0] clr_bits;
   logic [31:0] pend;
   logic [2:0] fld;
   // main register and routing logic
   always_comb begin
      s_d = s_q;
      acc = (avs_read || avs_write) && s_q.wait_n == 1'b0;
      mbox_wr = '0;
      clr_bits = '0;
      set_bits = '0;
      fld = '0;
      // one wait state: the access completes on the second cycle
      s_d.wait_n = acc;
      if (s_q.wait_n) begin
         s_d.wait_n = 1'b0;
      end
      if (acc && avs_write) begin
         case (avs_address)
            vir_pkg::OFS_LOCAL_ROUTE_2: begin
               s_d.local_route = merge(s_q.local_route, avs_writedata, avs_byteenable,
                                       vir_pkg::LOCAL_ROUTE_MASK); // [RULE8] [RULE13]
            end
            vir_pkg::OFS_MAILBOX_VME_ROUTE: begin
               s_d.vme_route = merge(s_q.vme_route, avs_writedata, avs_byteenable,
                                     vir_pkg::VME_ROUTE_MASK); // [RULE10] [RULE13]
            end
            vir_pkg::OFS_IRQ_ENABLE: begin
               s_d.enable = merge(s_q.enable, avs_writedata, avs_byteenable, vir_pkg::STAT_IMPL_MASK);
            end
            vir_pkg::OFS_IRQ_STATUS: begin
               clr_bits = merge('0, avs_writedata, avs_byteenable, vir_pkg::STAT_IMPL_MASK);
            end
            vir_pkg::OFS_MAILBOX0, vir_pkg::OFS_MAILBOX1, vir_pkg::OFS_MAILBOX2,
            vir_pkg::OFS_MAILBOX3: begin
               for (int m = 0; m < vir_pkg::NUM_MBOX; m++) begin
                  if (avs_address == vir_pkg::OFS_MAILBOX0 + 12'(m * 4)) begin
                     s_d.mailbox[m] = merge(s_q.mailbox[m], avs_writedata, avs_byteenable, '1);
                     mbox_wr[m] = 1'b1; // [RULE12]
                  end
               end
            end
            default: begin
               // vector registers are read-only; unmapped writes are dropped [RULE14]
            end
         endcase
      end
      if (acc && avs_read) begin
         case (avs_address)
            vir_pkg::OFS_LEVEL5_VECTOR: s_d.rdata = vec_word[0];
            vir_pkg::OFS_LEVEL6_VECTOR: s_d.rdata = vec_word[1];
            vir_pkg::OFS_LEVEL7_VECTOR: s_d.rdata = vec_word[2];
            vir_pkg::OFS_LOCAL_ROUTE_2: s_d.rdata = s_q.local_route;
            vir_pkg::OFS_MAILBOX_VME_ROUTE: s_d.rdata = s_q.vme_route;
            vir_pkg::OFS_IRQ_ENABLE: s_d.rdata = s_q.enable;
            vir_pkg::OFS_IRQ_STATUS: s_d.rdata = s_q.status;
            vir_pkg::OFS_MAILBOX0: s_d.rdata = s_q.mailbox[0];
            vir_pkg::OFS_MAILBOX1: s_d.rdata = s_q.mailbox[1];
            vir_pkg::OFS_MAILBOX2: s_d.rdata = s_q.mailbox[2];
            vir_pkg::OFS_MAILBOX3: s_d.rdata = s_q.mailbox[3];
            default: s_d.rdata = vir_pkg::UNMAPPED_READ;
         endcase
      end
      // sticky status: set wins over a write-one clear
      set_bits[vir_pkg::STAT_LEVEL_LSB +: 3] = cap_pulse; // [RULE5]
      set_bits[vir_pkg::STAT_MBOX_LSB +: 4] = mbox_wr; // [RULE12]
      s_d.status = (s_q.status & ~clr_bits) | set_bits;
      pend = s_q.status & s_q.enable;
      s_d.irq = |pend; // [RULE5]
      // steer sources to local and vme lines
      s_d.lline = '0;
      s_d.vline = '0;
      for (int k = 0; k < vir_pkg::NUM_SRC; k++) begin
         fld = s_q.local_route[k*vir_pkg::ROUTE_NIBBLE +: vir_pkg::ROUTE_W];
         // sources 0-3 mailboxes, 4-7 location monitors
         if ((k < 4) ? pend[vir_pkg::STAT_MBOX_LSB + k] : locmon_event[k-4]) begin
            s_d.lline[fld] = 1'b1; // [RULE9]
         end
      end
      for (int k = 0; k < vir_pkg::NUM_MBOX; k++) begin
         fld = s_q.vme_route[k*vir_pkg::ROUTE_NIBBLE +: vir_pkg::ROUTE_W];
         // value zero masks: there is no vme line zero [RULE11]
         if (fld != 3'h0 && pend[vir_pkg::STAT_MBOX_LSB + k]) begin
            s_d.vline[fld - 3'h1] = 1'b1; // [RULE11]
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from flops, except waitrequest which is gated by read/write
   assign avs_readdata = s_q.rdata;
   assign avs_waitrequest = ~s_q.wait_n & (avs_read | avs_write);
   assign local_irq_line = s_q.lline;
   assign vme_irq_line = s_q.vline;
   assign irq = s_q.irq;
endmodule : vir_top

// File: inc/vir_pkg.sv
// package for the vme interrupt vector capture and routing block
// assumes a 32-bit avalon-mm register slave with word byte addresses
package vir_pkg;
   localparam int NUM_LEVELS = 3;
   localparam int FIRST_LEVEL = 5;
   localparam int NUM_SRC = 8;
   localparam int ROUTE_W = 3;
   localparam int NUM_LOCAL_LINES = 8;
   localparam int NUM_VME_LINES = 7;
   localparam int NUM_MBOX = 4;
   // register byte offsets
   localparam logic [11:0] OFS_LEVEL5_VECTOR = 12'h334;
   localparam logic [11:0] OFS_LEVEL6_VECTOR = 12'h338;
   localparam logic [11:0] OFS_LEVEL7_VECTOR = 12'h33C;
   localparam logic [11:0] OFS_LOCAL_ROUTE_2 = 12'h340;
   localparam logic [11:0] OFS_MAILBOX_VME_ROUTE = 12'h344;
   localparam logic [11:0] OFS_IRQ_ENABLE = 12'h360;
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h364;
   localparam logic [11:0] OFS_MAILBOX0 = 12'h348;
   localparam logic [11:0] OFS_MAILBOX1 = 12'h34C;
   localparam logic [11:0] OFS_MAILBOX2 = 12'h350;
   localparam logic [11:0] OFS_MAILBOX3 = 12'h354;
   // field positions
   localparam int VEC_ERR_BIT = 8;
   localparam int ROUTE_NIBBLE = 4;
   localparam int VME_ROUTE_USED = 16;
   // status/enable layout: bits 2:0 levels 5..7, bits 7:4 mailboxes 0..3
   localparam int STAT_LEVEL_LSB = 0;
   localparam int STAT_MBOX_LSB = 4;
   localparam logic [31:0] STAT_IMPL_MASK = 32'h0000_00F7;
   // reset value, write masks and unmapped read value
   localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;
   localparam logic [31:0] VME_ROUTE_MASK = 32'h0000_7777;
   localparam logic [31:0] LOCAL_ROUTE_MASK = 32'h7777_7777;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

   typedef struct packed {
      logic [7:0] vector;
      logic err;
   } vir_capture_t;

   typedef enum logic [1:0] {
      VIR_IDLE,
      VIR_ACK,
      VIR_WAIT_CLEAR
   } vir_ack_state_t;
endpackage : vir_pkg

// File: rtl/vir_level_handler.sv
// one interrupt-acknowledge handler for a single vme level
// assumes the outer ack port gives done with vector and bus error in one cycle
`timescale 1ns/1ps
module vir_level_handler (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic irq_pending,
   input wire logic status_set,
   output logic ack_req,
   input wire logic ack_done,
   input wire logic [7:0] ack_vector,
   input wire logic ack_berr,
   output logic capture,
   output vir_pkg::vir_capture_t captured
);
   typedef struct packed {
      vir_pkg::vir_ack_state_t st;
      vir_pkg::vir_capture_t cap;
      logic cap_pulse;
   } vir_lvl_state_t;

   vir_lvl_state_t s_q;
   vir_lvl_state_t s_d;

   // next-state logic for one level
   always_comb begin
      s_d = s_q;
      s_d.cap_pulse = 1'b0;
      case (s_q.st)
         vir_pkg::VIR_IDLE: begin
            // only handle while enabled and status clear [RULE3] [RULE4]
            if (enable && irq_pending && !status_set) begin
               s_d.st = vir_pkg::VIR_ACK;
            end
         end
         vir_pkg::VIR_ACK: begin
            if (ack_done) begin
               s_d.cap.vector = ack_vector; // own level only [RULE2]
               s_d.cap.err = ack_berr; // vector suspect on error [RULE6] [RULE7]
               s_d.cap_pulse = 1'b1; // raises the local interrupt [RULE5]
               s_d.st = vir_pkg::VIR_WAIT_CLEAR;
            end
         end
         vir_pkg::VIR_WAIT_CLEAR: begin
            // wait for the pulse to land before looking at status again
            if (!s_q.cap_pulse && !status_set) begin
               s_d.st = vir_pkg::VIR_IDLE; // [RULE4]
            end
         end
         default: begin
            s_d.st = vir_pkg::VIR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign ack_req = (s_q.st == vir_pkg::VIR_ACK);
   assign capture = s_q.cap_pulse;
   assign captured = s_q.cap;
endmodule : vir_level_handler

// File: verif/vir_sva.sv
// checker on the ports of the vector capture and routing top
// assumes a single clock domain; bound to the top at the foot of this file
`timescale 1ns/1ps
module vir_sva #(
   parameter int NUM_LEVELS = 3
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [NUM_LEVELS-1:0] vme_irq_pending,
   input wire logic [NUM_LEVELS-1:0] vme_ack_req,
   input wire logic [NUM_LEVELS-1:0] vme_ack_done,
   input wire logic [3:0] locmon_event,
   input wire logic [7:0] local_irq_line,
   input wire logic [6:0] vme_irq_line,
   input wire logic irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // reset must win over everything, so this one ignores the default disable
   out_reset_a: assert property (disable iff (1'b0)
      !rst_n |-> !irq && vme_ack_req == '0 && local_irq_line == '0 && vme_irq_line == '0) else $error("outputs busy");
   bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest too long");
   // an acknowledge only starts for an asserted interrupt
   ack_cause_a: assert property ((vme_ack_req & ~$past(vme_ack_req) & ~$past(vme_irq_pending)) == '0)
      else $error("ack without interrupt");
   no_reack_a: assert property (vme_ack_done[0] |-> ##2 !vme_ack_req[0] [*3])
      else $error("ack repeated before clear");
   irq_follow_a: assert property (vme_ack_done != '0 |-> ##[1:3] irq)
      else $error("no interrupt after capture");
   locmon_line_a: assert property ($rose(|locmon_event) |-> ##[1:3] local_irq_line != '0)
      else $error("monitor not routed");
   // read data stand at the edge where waitrequest is low
   vec_rsvd_a: assert property (avs_read && !avs_waitrequest && avs_address inside {12'h334, 12'h338, 12'h33C}
      |-> avs_readdata[31:9] == '0) else $error("vector reserved bits set");
   lroute_rsvd_a: assert property (avs_read && !avs_waitrequest && avs_address == 12'h340
      |-> (avs_readdata & 32'h8888_8888) == '0) else $error("local route reserved bits set");
   vroute_rsvd_a: assert property (avs_read && !avs_waitrequest && avs_address == 12'h344
      |-> (avs_readdata & 32'hFFFF_8888) == '0) else $error("vme route reserved bits set");
endmodule : vir_sva

bind vir_top vir_sva #(.NUM_LEVELS(NUM_LEVELS)) chk (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .vme_irq_pending(vme_irq_pending), .vme_ack_req(vme_ack_req), .vme_ack_done(vme_ack_done),
   .locmon_event(locmon_event), .local_irq_line(local_irq_line), .vme_irq_line(vme_irq_line), .irq(irq));

// File: verif/vir_vme_side.sv
// vme side model: interrupters answering acknowledge cycles, one level at a time
// assumes the handler holds its request until answered and then drops it
`timescale 1ns/1ps
module vir_vme_side (
   input wire logic clock,
   input wire logic [2:0] ack_req,
   input wire logic [7:0] vec_src,
   input wire logic berr_src,
   output logic [2:0] ack_done,
   output logic [7:0] ack_vector,
   output logic ack_berr
);
   int seed = 5;
   // answer after zero to three cycles; data lines carry junk outside the pulse
   initial begin
      ack_done = 3'h0;
      ack_vector = 8'h5A;
      ack_berr = 1'b1;
      forever begin
         @(posedge clock);
         for (int i = 0; i < 3; i++) begin
            if (ack_req[i] === 1'b1) begin
               repeat ({$random(seed)} % 4) @(posedge clock);
               ack_done[i] <= 1'b1;
               ack_vector <= vec_src;
               ack_berr <= berr_src;
               @(posedge clock);
               ack_done <= 3'h0;
               ack_vector <= ~vec_src;
               ack_berr <= ~berr_src;
               while (ack_req[i] === 1'b1) @(posedge clock);
            end
         end
      end
   end
endmodule : vir_vme_side

// File: verif/testbench.sv
// testbench: registers, routing and vector capture of the vme interrupt top
// assumes the vme side model answers with vec_src and berr_src
`timescale 1ns/1ps
module testbench;
   logic clock = 1'b0, rst_n = 1'b1, avs_read = 1'b0, avs_write = 1'b0, berr_src = 1'b0;
   logic [11:0] avs_address = 12'h000;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic avs_waitrequest, vme_ack_berr, irq;
   logic [2:0] vme_irq_pending = 3'h0, vme_ack_req, vme_ack_done;
   logic [7:0] vme_ack_vector, local_irq_line, vec_src = 8'h00;
   logic [3:0] locmon_event = 4'h0;
   logic [6:0] vme_irq_line;
   logic [31:0] exp_vec [3] = '{default: 32'h0};
   int n_mismatch = 0, total_checks = 0, seed = 86443;
   initial begin
      forever #5 clock = ~clock;
   end
   vir_top uut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .vme_irq_pending(vme_irq_pending), .vme_ack_req(vme_ack_req),
      .vme_ack_done(vme_ack_done), .vme_ack_vector(vme_ack_vector), .vme_ack_berr(vme_ack_berr),
      .locmon_event(locmon_event), .local_irq_line(local_irq_line), .vme_irq_line(vme_irq_line), .irq(irq));
   vir_vme_side vme (.clock(clock), .ack_req(vme_ack_req), .vec_src(vec_src), .berr_src(berr_src),
      .ack_done(vme_ack_done), .ack_vector(vme_ack_vector), .ack_berr(vme_ack_berr));
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h want %h", $time, seen, want);
      end
   endtask : check
   // one transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= d;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic rchk(input logic [11:0] a, input logic [31:0] want);
      bus(1'b0, a, 32'h0);
      check(rd, want);
   endtask : rchk
   task automatic wait_irq(input logic want);
      repeat (40) if (irq !== want) @(posedge clock);
      check({31'h0, irq}, {31'h0, want});
   endtask : wait_irq
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish
   // bounded run: the scenarios need well under this
   initial begin
      #100us;
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      // a real falling edge, so the asynchronous reset branches run at all
      rst_n <= 1'b0;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      // reset values, unmapped place, read-only vector
      for (int i = 0; i < 5; i++) rchk(12'h334 + 12'(4 * i), 32'h0);
      rchk(12'h000, 32'h0);
      bus(1'b1, 12'h334, 32'hFFFF_FFFF);
      rchk(12'h334, 32'h0);
      bus(1'b1, 12'h340, 32'hFFFF_FFFF);
      rchk(12'h340, 32'h7777_7777);
      bus(1'b1, 12'h344, 32'hFFFF_FFFF);
      rchk(12'h344, 32'h0000_7777);
      // every route code steers a location monitor to its local line
      for (int k = 0; k < 8; k++) begin
         bus(1'b1, 12'h340, 32'(k) << (16 + 4 * (k % 4)));
         locmon_event <= 4'(1 << (k % 4));
         repeat (3) @(posedge clock);
         check({24'h0, local_irq_line}, 32'(1 << k));
         locmon_event <= 4'h0;
      end
      // mailbox writes: sticky status, masked at r 2, route 0 masks the vme side
      bus(1'b1, 12'h340, 32'h0);
      for (int r = 0; r < 8; r++) begin
         bus(1'b1, 12'h360, (r != 2) ? 32'h10 : 32'h0);
         bus(1'b1, 12'h344, 32'(r));
         bus(1'b1, 12'h348, $random(seed));
         repeat (3) @(posedge clock);
         rchk(12'h364, 32'h10);
         check({31'h0, irq}, 32'(r != 2));
         check({25'h0, vme_irq_line}, (r != 2 && r != 0) ? 32'(1 << (r - 1)) : 32'h0);
         bus(1'b1, 12'h364, 32'h10);
         wait_irq(1'b0);
      end
      // a level that is not enabled gets no acknowledge
      bus(1'b1, 12'h360, 32'h0);
      vme_irq_pending <= 3'h7;
      repeat (10) @(posedge clock);
      check({29'h0, vme_ack_req}, 32'h0);
      vme_irq_pending <= 3'h0;
      bus(1'b1, 12'h360, 32'h7);
      // capture per level, clean then with bus error, no repeat before clear
      for (int j = 0; j < 6; j++) begin
         int l;
         l = j % 3;
         vec_src <= 8'($random(seed));
         berr_src <= (j > 2);
         vme_irq_pending <= 3'(1 << l);
         wait_irq(1'b1);
         vme_irq_pending <= 3'h0;
         exp_vec[l] = {23'h0, (j > 2), vec_src};
         for (int i = 0; i < 3; i++) rchk(12'h334 + 12'(4 * i), exp_vec[i]);
         vme_irq_pending <= 3'(1 << l);
         repeat (8) @(posedge clock);
         check({29'h0, vme_ack_req}, 32'h0);
         vme_irq_pending <= 3'h0;
         bus(1'b1, 12'h364, 32'(1 << l));
         wait_irq(1'b0);
      end
      tally_and_finish();
   end
endmodule : testbench
